//--- dv/bus_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------
// Two-wire bus master, one bit per call.
// ---------------------------------------
module bus_master_model #(
   parameter int half = 30
) (
   input wire logic clock,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_clk
   // Data moves only while the clock is low, so no false start or stop is seen.
   task automatic bit_io(input logic b, output logic r);
      wait_clk(half / 4);
      sda_low = ~b;
      wait_clk(half);
      scl = 1'b1;
      wait_clk(half);
      r = sda;
      scl = 1'b0;
   endtask : bit_io
   task automatic start_cond();
      wait_clk(half);
      sda_low = 1'b1;
      wait_clk(half);
      scl = 1'b0;
   endtask : start_cond
   task automatic stop_cond();
      wait_clk(half / 4);
      sda_low = 1'b1;
      wait_clk(half);
      scl = 1'b1;
      wait_clk(half);
      sda_low = 1'b0;
      wait_clk(half);
   endtask : stop_cond
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : put_byte
   // A set last bit answers the final byte with a release, ending the read.
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask : get_byte
endmodule : bus_master_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(what, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
   import io_expander_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] strap = 3'h0;
   logic [7:0] ext = 8'hFF;
   int checks = 0;
   int fail_count = 0;
   wire logic scl;
   wire logic m_low;
   wire logic sda_oe;
   wire logic sda_level;
   wire logic alt_oe;
   wire logic sda = ~(m_low | (sda_oe & ~sda_level) | alt_oe);
   wire logic [7:0] port_oe;
   wire logic [7:0] port_level;
   wire logic [7:0] alt_port_oe;
   wire logic alert_n_oe;
   wire logic alert_level;
   wire logic alert_line = ~(alert_n_oe & ~alert_level);
   wire logic [7:0] pins = ext & ~(port_oe & ~port_level);
   initial forever #5 clock = ~clock;
   bus_master_model bus_master_model_inst (.clock(clock), .sda(sda), .scl(scl), .sda_low(m_low));
   serial_io_expander_8bit serial_io_expander_8bit_inst (.clock(clock), .rstn(rstn),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_level), .sda_oe(sda_oe), .addr_strap(strap),
      .port_in(pins), .port_out(port_level), .port_oe(port_oe), .alert_n_out(alert_level),
      .alert_n_oe(alert_n_oe));
   serial_io_expander_8bit #(.fixed_addr(4'h7)) alt_inst (.clock(clock), .rstn(rstn),
      .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(alt_oe), .addr_strap(strap),
      .port_in(8'hFF), .port_out(), .port_oe(alt_port_oe), .alert_n_out(), .alert_n_oe());
   task automatic tally_and_finish();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   // A written zero pulls its pin low; a written one lets it float.
   function automatic logic [7:0] expect_drive(input logic [7:0] written);
      return ~written;
   endfunction : expect_drive
   // A released pin reads the outside level; a driven one reads low.
   function automatic logic [7:0] expect_pins(input logic [7:0] written, input logic [7:0] level);
      return written & level;
   endfunction : expect_pins
   task automatic xfer(input logic [6:0] a, input logic rd, inout logic [7:0] d,
                       output logic ack);
      logic k;
      bus_master_model_inst.start_cond();
      bus_master_model_inst.put_byte({a, rd}, ack);
      if (ack && rd) bus_master_model_inst.get_byte(1'b1, d);
      if (ack && !rd) bus_master_model_inst.put_byte(d, k);
      bus_master_model_inst.stop_cond();
   endtask : xfer
   task automatic wait_alert(input logic v);
      for (int n = 0; n < 20 && alert_n_oe !== v; n++) begin
         @(posedge clock);
         #1;
      end
      `CHECK("alert", v, alert_n_oe)
      `CHECK("alert_line", ~v, alert_line)
      if (alert_n_oe !== v) tally_and_finish();
   endtask : wait_alert
   initial begin
      repeat (100000) @(posedge clock);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      logic ack;
      logic [7:0] d;
      logic [7:0] e;
      logic [7:0] got;
      logic [7:0] tmp;
      logic [2:0] s;
      logic [7:0] got2;
      d = 8'($urandom(32'h021F));
      repeat (3) @(posedge clock);
      #1 rstn = 1'b1;
      `CHECK("port_oe", 8'h00, port_oe)
      `CHECK("alert", 1'b0, alert_n_oe)
      `CHECK("sda_oe", 1'b0, sda_oe)
      for (int i = 0; i < 8; i++) begin
         s = i[2:0];
         d = 8'($urandom);
         e = 8'($urandom);
         strap = s;
         ext = e;
         bus_master_model_inst.wait_clk(5);
         tmp = d;
         xfer({4'h4, s}, 1'b0, tmp, ack);
         `CHECK("ack", 1'b1, ack)
         `CHECK("port_oe", expect_drive(d), port_oe)
         tmp = ~d;
         xfer({4'h4, s ^ 3'h1}, 1'b0, tmp, ack);
         `CHECK("ack", 1'b0, ack)
         tmp = ~d;
         xfer({4'h7, s}, 1'b0, tmp, ack);
         `CHECK("ack", 1'b1, ack)
         `CHECK("port_oe", expect_drive(d), port_oe)
         `CHECK("alt_port_oe", expect_drive(~d), alt_port_oe)
         xfer({4'h4, s}, 1'b1, got, ack);
         `CHECK("read", expect_pins(d, e), got)
         `CHECK("alert", 1'b0, alert_n_oe)
      end
      tmp = 8'hFF;
      xfer({4'h4, s}, 1'b0, tmp, ack);
      xfer({4'h4, s}, 1'b1, got, ack);
      d = e ^ (8'h01 << $urandom_range(7, 0));
      ext = d;
      wait_alert(1'b1);
      ext = e;
      wait_alert(1'b0);
      ext = d;
      wait_alert(1'b1);
      xfer({4'h4, s}, 1'b1, got, ack);
      `CHECK("read", d, got)
      wait_alert(1'b0);
      bus_master_model_inst.start_cond();
      bus_master_model_inst.put_byte({4'h4, s, 1'b1}, ack);
      bus_master_model_inst.get_byte(1'b0, got);
      bus_master_model_inst.get_byte(1'b1, got2);
      bus_master_model_inst.stop_cond();
      `CHECK("ack", 1'b1, ack)
      `CHECK("read", d, got)
      `CHECK("read2", d, got2)
      tmp = 8'h00;
      xfer({4'h4, s}, 1'b0, tmp, ack);
      `CHECK("port_oe", expect_drive(8'h00), port_oe)
      rstn = 1'b0;
      bus_master_model_inst.wait_clk(3);
      `CHECK("port_oe", 8'h00, port_oe)
      rstn = 1'b1;
      xfer({4'h4, s}, 1'b1, got, ack);
      `CHECK("read", expect_pins(8'hFF, d), got)
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire

//--- rtl/io_expander_consts.svh
// Notes on behaviour
// - Eight quasi-bidirectional pins behind a serial slave.
// - Writes go to the port latch; reads sample the pins.
// - Written outputs held until next write.
// - Alert whenever pins differ from input register.
// - Alert is active low, open drain.
// - Reset leaves all pins released, reading high.
// - Three straps select one of eight addresses.
// - Variants differ only in fixed address part.
// - Last address bit: one read, zero write.
// - Fixed part bits six-three, straps two-zero.
// - Reads return live pin levels.
// - Zero drives pin low, one releases it.
`ifndef IO_EXPANDER_CONSTS_SVH
`define IO_EXPANDER_CONSTS_SVH

`define PORT_WIDTH 8
`define ADDR_WIDTH 7
`define STRAP_WIDTH 3
`define FIXED_WIDTH 4
`define FIXED_ADDR_STD 4'h4
`define FIXED_ADDR_ALT 4'h7
`define BUS_RATE_KHZ 400
`define BYTE_BITS 4'h8
`define READ_LAST_BIT 4'h7
`define PORT_RESET 8'hFF
`define DRIVE_RESET 8'h00
`define STRAP_RESET 3'h0

`endif

//--- rtl/io_expander_pkg.sv
package io_expander_pkg;

   typedef struct packed {
      logic scl;
      logic sda;
   } bus_lines_t;

   typedef enum logic [5:0] {
      st_idle = 6'h01,
      st_addr = 6'h02,
      st_addr_ack = 6'h04,
      st_write = 6'h08,
      st_write_ack = 6'h10,
      st_read = 6'h20
   } slave_state_t;

endpackage : io_expander_pkg

//--- rtl/serial_io_expander_8bit.sv
`timescale 1ns/1ns
`default_nettype none
`include "io_expander_consts.svh"

module serial_io_expander_8bit
   import io_expander_pkg::*;
#(
   parameter logic [`FIXED_WIDTH-1:0] fixed_addr = `FIXED_ADDR_STD
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [`STRAP_WIDTH-1:0] addr_strap,
   input wire logic [`PORT_WIDTH-1:0] port_in,
   output logic [`PORT_WIDTH-1:0] port_out,
   output logic [`PORT_WIDTH-1:0] port_oe,
   output logic alert_n_out,
   output logic alert_n_oe
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   bus_lines_t bus_meta;
   bus_lines_t bus_sync;
   bus_lines_t bus_prev;
   logic [`PORT_WIDTH-1:0] port_meta;
   logic [`PORT_WIDTH-1:0] port_sync;
   logic [`STRAP_WIDTH-1:0] strap_meta;
   logic [`STRAP_WIDTH-1:0] strap_sync;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bus_meta <= '1;
         bus_sync <= '1;
         bus_prev <= '1;
      end else begin
         bus_meta <= '{scl: scl_in, sda: sda_in};
         bus_sync <= bus_meta;
         bus_prev <= bus_sync;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         port_meta <= `PORT_RESET;
         port_sync <= `PORT_RESET;
         strap_meta <= `STRAP_RESET;
         strap_sync <= `STRAP_RESET;
      end else begin
         port_meta <= port_in;
         port_sync <= port_meta;
         strap_meta <= addr_strap;
         strap_sync <= strap_meta;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [`ADDR_WIDTH-1:0] own_addr;

   assign scl_rise = bus_sync.scl && !bus_prev.scl;
   assign scl_fall = !bus_sync.scl && bus_prev.scl;
   assign bus_start = bus_sync.scl && bus_prev.scl && bus_prev.sda && !bus_sync.sda;
   assign bus_stop = bus_sync.scl && bus_prev.scl && !bus_prev.sda && bus_sync.sda;
   assign own_addr = {fixed_addr, strap_sync};

   // ----------------------------------------------------------------
   // Serial slave sequencer
   // ----------------------------------------------------------------
   slave_state_t state;
   logic [`PORT_WIDTH-1:0] shift;
   logic [3:0] bit_cnt;
   logic rw;
   logic [`PORT_WIDTH-1:0] in_reg;
   logic [`PORT_WIDTH-1:0] drive_low;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= st_idle;
         shift <= `DRIVE_RESET;
         bit_cnt <= 4'h0;
         rw <= 1'b0;
      end else if (bus_start) begin
         state <= st_addr;
         bit_cnt <= 4'h0;
      end else if (bus_stop) begin
         state <= st_idle;
      end else begin
         case (state)
            st_addr, st_write: begin
               if (scl_rise && bit_cnt != `BYTE_BITS) begin
                  shift <= {shift[`PORT_WIDTH-2:0], bus_sync.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
                  bit_cnt <= 4'h0;
                  if (state == st_write) begin
                     state <= st_write_ack;
                  end else if (shift[`PORT_WIDTH-1:1] == own_addr) begin
                     rw <= shift[0];
                     state <= st_addr_ack;
                  end else begin
                     state <= st_idle;
                  end
               end
            end
            st_addr_ack, st_write_ack: begin
               if (scl_fall) begin
                  if (state == st_addr_ack && rw) begin
                     shift <= port_sync;
                     state <= st_read;
                  end else begin
                     state <= st_write;
                  end
               end
            end
            st_read: begin
               if (scl_fall) begin
                  if (bit_cnt == `READ_LAST_BIT) begin
                     bit_cnt <= `BYTE_BITS;
                  end else if (bit_cnt == `BYTE_BITS) begin
                     bit_cnt <= 4'h0;
                     shift <= port_sync;
                  end else begin
                     shift <= {shift[`PORT_WIDTH-2:0], 1'b1};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end else if (scl_rise && bit_cnt == `BYTE_BITS && bus_sync.sda) begin
                  state <= st_idle;
               end
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // Open-drain data line: the enable pulls the line low.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sda_oe <= 1'b0;
      end else begin
         case (state)
            st_addr_ack, st_write_ack: sda_oe <= 1'b1;
            st_read: sda_oe <= (bit_cnt != `BYTE_BITS) && !shift[`PORT_WIDTH-1];
            default: sda_oe <= 1'b0;
         endcase
      end
   end

   assign sda_out = 1'b0;

   // ----------------------------------------------------------------
   // Port latch and pin drive
   // ----------------------------------------------------------------
   logic take_write;
   logic take_read;

   assign take_write = (state == st_write) && scl_fall && (bit_cnt == `BYTE_BITS) && !bus_start;
   assign take_read = (state == st_addr_ack) && rw && scl_fall && !bus_start && !bus_stop;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         drive_low <= `DRIVE_RESET;
      end else if (take_write) begin
         drive_low <= ~shift;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `PORT_WIDTH; gi = gi + 1) begin : g_pin
         assign port_oe[gi] = drive_low[gi];
         assign port_out[gi] = 1'b0;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Change alert
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         in_reg <= `PORT_RESET;
      end else if (take_read) begin
         in_reg <= port_sync;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         alert_n_oe <= 1'b0;
      end else begin
         alert_n_oe <= (port_sync != in_reg) && !take_read;
      end
   end

   assign alert_n_out = 1'b0;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_alert_follows_diff: assert property (@(posedge clock) disable iff (!rstn)
      !take_read |=> alert_n_oe == $past(port_sync != in_reg))
      else $error("alert does not follow pin difference");

   a_alert_never_high: assert property (@(posedge clock) disable iff (!rstn)
      alert_n_oe |-> !alert_n_out && $past(port_sync != in_reg))
      else $error("alert drives high level");

   a_latch_holds: assert property (@(posedge clock) disable iff (!rstn)
      !$stable(drive_low) |-> $past(state) == st_write && $past(bit_cnt) == `BYTE_BITS)
      else $error("port latch changed outside write");

   a_write_inverts: assert property (@(posedge clock) disable iff (!rstn)
      take_write |=> port_oe == ~$past(shift) && state == st_write_ack)
      else $error("written byte not on pin drive");

   a_addr_match: assert property (@(posedge clock) disable iff (!rstn)
      $rose(state == st_addr_ack) |-> $past(shift[`PORT_WIDTH-1:1]) == {fixed_addr, strap_sync})
      else $error("acknowledged foreign address");

   a_read_dir: assert property (@(posedge clock) disable iff (!rstn)
      $rose(state == st_read) |-> rw && $past(state) == st_addr_ack)
      else $error("read entered without read direction");

   a_read_live: assert property (@(posedge clock) disable iff (!rstn)
      take_read |=> shift == $past(port_sync) && in_reg == $past(port_sync))
      else $error("read byte not live pin level");

   a_idle_release: assert property (@(posedge clock) disable iff (!rstn)
      (state == st_idle)[*2] |-> !sda_oe)
      else $error("data line driven while idle");

   c_write_byte: cover property (@(posedge clock) disable iff (!rstn) take_write);
   c_read_byte: cover property (@(posedge clock) disable iff (!rstn) take_read);
   c_alert_clear: cover property (@(posedge clock) disable iff (!rstn)
      alert_n_oe ##1 take_read ##1 !alert_n_oe);
   c_foreign_addr: cover property (@(posedge clock) disable iff (!rstn)
      state == st_addr ##1 state == st_idle);
   c_read_next_byte: cover property (@(posedge clock) disable iff (!rstn)
      state == st_read && scl_fall && bit_cnt == `BYTE_BITS);

endmodule : serial_io_expander_8bit
`default_nettype wire
